// File: logic/wake_pkg.sv
/*
 Shared constants and carrier types for the wake-up source controller.
 Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package wake_pkg;
    localparam int          NUM_EXT      = 4;
    localparam int          CRYSTAL_CLOCK_DIV     = 128;
    localparam int          STAT_W       = 7;

    // Register byte offsets
    localparam logic [31:0] OFS_CTRL     = 32'h0000_0000;
    localparam logic [31:0] OFS_STAT     = 32'h0000_0004;
    localparam logic [31:0] OFS_MASK     = 32'h0000_0008;

    // Field positions of the control word
    localparam int          POS_TIMER_EN = 0;
    localparam int          POS_CAL_EN   = 1;
    localparam int          POS_HOST     = 2;
    localparam int          POS_AUTO     = 3;
    localparam int          POS_EN       = 4;
    localparam int          POS_SENSE    = 8;
    localparam int          POS_POL      = 12;

    // Field positions of the status and mask words
    localparam int          POS_ST_EXT   = 0;
    localparam int          POS_ST_TIMER = 4;
    localparam int          POS_ST_CAL   = 5;
    localparam int          POS_ST_CONV  = 6;

    localparam logic [15:0] CTRL_RESET   = 16'hf000;
    localparam logic [6:0]  STAT_RESET   = 7'h00;
    localparam logic [6:0]  MASK_RESET   = 7'h00;

    typedef struct packed {
        logic [3:0] pol;
        logic [3:0] sense_edge;
        logic [3:0] en;
        logic       auto_conv;
        logic       host_wake;
        logic       cal_en;
        logic       timer_en;
    } ctrl_t;

    typedef struct packed {
        logic       conv;
        logic       cal;
        logic       timer;
        logic [3:0] ext;
    } stat_t;

    typedef struct packed {
        ctrl_t       ctrl;
        stat_t       stat;
        stat_t       mask;
        logic        ack;
        logic [31:0] rdata;
        logic        pin;
        logic        pin_oe;
    } main_state_t;
endpackage

// File: logic/wake_tick_div.sv
/*
 Divider giving a one-cycle enable pulse every DIV cycles of clk_i.
 Assumes clk_i stands for the crystal clock.
*/
`timescale 1ns/1ps
module wake_tick_div #(
    parameter int DIV = wake_pkg::CRYSTAL_CLOCK_DIV
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);
    localparam int CW = $clog2(DIV);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } div_state_t;

    div_state_t st_reg;
    div_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = (st_reg.cnt == CW'(DIV - 1));
        if (st_next.tick) begin
            st_next.cnt = '0;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_o = st_reg.tick;

    a_tick_gap: assert property ( // R6
        @(posedge clk_i) disable iff (rst_i)
        tick_o |=> !tick_o [*8])
        else $error("divided tick came too soon");
endmodule

// File: logic/wake_edge_detect.sv
/*
 Two-stage synchroniser and change detector per wake input, stepped by
 a tick enable. Assumes pins are held for at least two ticks.
*/
`timescale 1ns/1ps
module wake_edge_detect #(
    parameter int N = wake_pkg::NUM_EXT
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_i,
    input  wire logic [N-1:0] pin_i,
    output logic      [N-1:0] level_o,
    output logic      [N-1:0] change_o
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] prev;
        logic         tick_d;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick_d = tick_i;
        if (tick_i) begin
            st_next.s1   = pin_i;     // R19
            st_next.s2   = st_reg.s1; // R19
            st_next.prev = st_reg.s2;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o  = st_reg.s2;
    assign change_o = st_reg.tick_d ? (st_reg.s2 ^ st_reg.prev) : '0;

    a_sync_hold: assert property ( // R19
        @(posedge clk_i) disable iff (rst_i)
        !$past(tick_i) |-> $stable(level_o))
        else $error("synchronised level moved without a tick");
endmodule

// File: logic/sleep_wakeup_source_control.sv
/*
 Wake-up source control: external wake inputs with level or edge sense,
 timer and calendar compare sources, autonomous converter mode, host
 wake output pin, sticky status with mask and one interrupt line, all
 reached over classic Wishbone. Assumes all inputs are synchronous to
 clk_i and that slow_tick_i pulses once per low-speed clock period.
*/
// The register offsets and the Wishbone slave port were decided locally.
// Notes on behaviour
// R1 - Sense bits per input: 1 edge, 0 level; level after reset.
// R2 - Level mode wakes while enabled and input equals its polarity.
// R3 - Level request clears only after the input goes inactive.
// R4 - Edge mode wakes on an active edge; status clearable any time.
// R5 - Wake pulses last at least two edge-detector clocks.
// R6 - Detector steps on the low-speed clock in hibernate, crystal/128 else.
// R7 - Four enable bits choose which inputs may wake; reset zero.
// R8 - With no input enabled software enables a timer source.
// R9 - Autonomous mode wakes only the converter; CPU waits for interrupt.
// R10 - On converter interrupt software clears autonomous mode first.
// R11 - Autonomous mode only in hibernate with state retention set; auto_conv here acts in every power mode.
// R12 - Pair autonomous mode with calendar wakes and a watchdog timer.
// R13 - Host-wake bit makes pin zero low in sleep, high when awake.
// R14 - Host-wake overrides general output; clearing returns control.
// R15 - Enabling host-wake lifts a pin programmed low to high.
// R16 - Bit 1 enables calendar compare wake; reset zero.
// R17 - Bit 0 enables timer compare wake; reset zero.
// R18 - Polarity 1 means high or rising, the default; 0 low or falling.
// R19 - Each input is synchronised in two stages before evaluation.
`timescale 1ns/1ps
module sleep_wakeup_source_control #(
    parameter int N   = wake_pkg::NUM_EXT,
    parameter int DIV = wake_pkg::CRYSTAL_CLOCK_DIV
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Classic Wishbone slave
    input  wire logic         cyc_i,
    input  wire logic         stb_i,
    input  wire logic         we_i,
    input  wire logic [31:0]  adr_i,
    input  wire logic [3:0]   sel_i,
    input  wire logic [31:0]  dat_i,
    output logic      [31:0]  dat_o,
    output logic              ack_o,
    // Power mode and wake sources
    input  wire logic         sleep_hib_i,
    input  wire logic         sleep_doze_i,
    input  wire logic         slow_tick_i,
    input  wire logic [N-1:0] keypad_wake_input_i,
    input  wire logic         timer_cmp_i,
    input  wire logic         cal_cmp_i,
    input  wire logic         conv_irq_i,
    input  wire logic         conv_done_i,
    // General output programming of the shared pin
    input  wire logic         shared_gpo_i,
    input  wire logic         shared_gpo_oe_i,
    // Results
    output logic              wake_output_pin_o,
    output logic              wake_output_pin_oe_o,
    output logic              wake_req_o,
    output logic              cpu_wake_o,
    output logic              conv_wake_o,
    output logic              irq_o
);
    wake_pkg::main_state_t st_reg;
    wake_pkg::main_state_t st_next;

    logic         div_tick;
    logic         det_tick;
    logic [N-1:0] sync_level;
    logic [N-1:0] sync_change;
    logic [N-1:0] active_match;
    logic [N-1:0] level_set;
    logic [N-1:0] edge_set;
    logic         bus_req;
    logic         bus_write;
    logic         asleep;
    logic         wake_any;
    wake_pkg::stat_t stat_set;
    wake_pkg::stat_t stat_clr;

    function automatic logic word_hit(input logic [31:0] adr,
                                      input logic [31:0] ofs);
        word_hit = (adr[31:2] == ofs[31:2]);
    endfunction

    function automatic logic [7:0] merge_byte(input logic [7:0] old_b,
                                              input logic [7:0] new_b,
                                              input logic       lane);
        merge_byte = lane ? new_b : old_b;
    endfunction

    wake_tick_div #(
        .DIV    (DIV)
    ) u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (div_tick)
    );

    // Hibernate steps on the low-speed clock, doze and run on crystal/128
    assign det_tick = sleep_hib_i ? slow_tick_i : div_tick; // R6

    wake_edge_detect #(
        .N        (N)
    ) u_det (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tick_i   (det_tick),
        .pin_i    (keypad_wake_input_i),
        .level_o  (sync_level),
        .change_o (sync_change)
    );

    assign bus_req   = cyc_i & stb_i;
    assign bus_write = bus_req & st_reg.ack & we_i;
    assign asleep    = sleep_hib_i | sleep_doze_i;

    // Input sits at its active level as chosen by polarity
    assign active_match = ~(sync_level ^ st_reg.ctrl.pol); // R18
    assign level_set    = st_reg.ctrl.en & ~st_reg.ctrl.sense_edge
                        & active_match; // R2
    // A change that lands on the active level is an active edge;
    // a pulse shorter than one tick may be missed
    assign edge_set     = st_reg.ctrl.en & st_reg.ctrl.sense_edge
                        & sync_change & active_match; // R4 R5

    always_comb begin
        stat_set       = '0;
        stat_set.ext   = level_set | edge_set; // R7
        stat_set.timer = timer_cmp_i & st_reg.ctrl.timer_en; // R17
        stat_set.cal   = cal_cmp_i & st_reg.ctrl.cal_en; // R16
        stat_set.conv  = conv_irq_i & st_reg.ctrl.auto_conv; // R9
    end

    always_comb begin
        stat_clr = '0;
        if (bus_write && word_hit(adr_i, wake_pkg::OFS_STAT)
            && sel_i[0]) begin
            stat_clr = wake_pkg::stat_t'(dat_i[wake_pkg::STAT_W-1:0]);
        end
        // Converter finished its sample: the timed request is spent
        if (st_reg.ctrl.auto_conv && conv_done_i) begin
            stat_clr.timer = 1'b1; // R9
            stat_clr.cal   = 1'b1; // R9
        end
    end

    always_comb begin
        st_next = st_reg;

        // A new event wins over a clear in the same cycle; a level input
        // still active re-arms its bit at once
        st_next.stat = (st_reg.stat & ~stat_clr) | stat_set; // R3 R4

        // Host-wake pin: low asleep, high awake, else general output
        if (st_reg.ctrl.host_wake) begin
            st_next.pin    = ~asleep; // R13 R15
            st_next.pin_oe = 1'b1; // R14
        end else begin
            st_next.pin    = shared_gpo_i; // R14
            st_next.pin_oe = shared_gpo_oe_i; // R14
        end

        // Bus: acknowledge one cycle after the request, then drop
        st_next.ack = bus_req & ~st_reg.ack;
        if (bus_req && !st_reg.ack) begin
            if (word_hit(adr_i, wake_pkg::OFS_CTRL)) begin
                st_next.rdata = {16'h0000, st_reg.ctrl};
            end else if (word_hit(adr_i, wake_pkg::OFS_STAT)) begin
                st_next.rdata = {25'h0000000, st_reg.stat};
            end else if (word_hit(adr_i, wake_pkg::OFS_MASK)) begin
                st_next.rdata = {25'h0000000, st_reg.mask};
            end else begin
                st_next.rdata = 32'h0000_0000;
            end
        end

        if (bus_write && word_hit(adr_i, wake_pkg::OFS_CTRL)) begin
            st_next.ctrl = wake_pkg::ctrl_t'({
                merge_byte(st_reg.ctrl[15:8], dat_i[15:8], sel_i[1]),
                merge_byte(st_reg.ctrl[7:0], dat_i[7:0], sel_i[0])
            }); // R1 R7 R16 R17 R18
        end
        if (bus_write && word_hit(adr_i, wake_pkg::OFS_MASK)
            && sel_i[0]) begin
            st_next.mask = wake_pkg::stat_t'(dat_i[wake_pkg::STAT_W-1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg        <= '0;
            st_reg.ctrl   <= wake_pkg::ctrl_t'(wake_pkg::CTRL_RESET); // R1
            st_reg.stat   <= wake_pkg::stat_t'(wake_pkg::STAT_RESET);
            st_reg.mask   <= wake_pkg::stat_t'(wake_pkg::MASK_RESET);
        end else begin
            st_reg <= st_next;
        end
    end

    assign wake_any = (|st_reg.stat.ext) | st_reg.stat.timer
                    | st_reg.stat.cal;

    // In autonomous mode only the converter wakes; the CPU waits for it
    assign conv_wake_o = st_reg.ctrl.auto_conv & wake_any; // R9
    assign cpu_wake_o  = st_reg.ctrl.auto_conv ? st_reg.stat.conv
                                               : wake_any; // R9
    assign wake_req_o  = wake_any | st_reg.stat.conv;
    assign irq_o       = |(st_reg.stat & st_reg.mask);

    assign wake_output_pin_o    = st_reg.pin;
    assign wake_output_pin_oe_o = st_reg.pin_oe;
    assign dat_o                = st_reg.rdata;
    assign ack_o                = st_reg.ack;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_reset_ctrl: assert property ( // R1
        $past(rst_i) |-> st_reg.ctrl == wake_pkg::CTRL_RESET)
        else $error("control word left reset with wrong value");

    a_level_wake: assert property ( // R2
        st_reg.ctrl.en[0] && !st_reg.ctrl.sense_edge[0]
        && sync_level[0] == st_reg.ctrl.pol[0]
        |=> st_reg.stat.ext[0] && wake_req_o)
        else $error("active level did not raise a wake");

    a_level_sticky: assert property ( // R3
        level_set[0] |=> st_reg.stat.ext[0]
        && (st_reg.ctrl.auto_conv || cpu_wake_o))
        else $error("level request cleared while input active");

    a_edge_set: assert property ( // R4
        edge_set[0] |=> st_reg.stat.ext[0])
        else $error("active edge was lost");

    a_edge_clear: assert property ( // R4
        bus_write && word_hit(adr_i, wake_pkg::OFS_STAT) && sel_i[0]
        && dat_i[0] && !stat_set.ext[0] |=> !st_reg.stat.ext[0])
        else $error("status clear was not honoured");

    a_enable_gate: assert property ( // R7
        !st_reg.ctrl.en[0] && !st_reg.stat.ext[0] && !stat_clr.ext[0]
        |=> !st_reg.stat.ext[0])
        else $error("disabled input set its status");

    a_conv_only: assert property ( // R9
        st_reg.ctrl.auto_conv && !st_reg.stat.conv |-> !cpu_wake_o)
        else $error("CPU woken in autonomous mode without interrupt");

    a_host_sleep: assert property ( // R13
        st_reg.ctrl.host_wake && asleep ##1 st_reg.ctrl.host_wake
        |-> !wake_output_pin_o && wake_output_pin_oe_o)
        else $error("host-wake pin not low in sleep");

    a_host_rise: assert property ( // R15
        $rose(st_reg.ctrl.host_wake) && !asleep && !$past(asleep)
        |=> wake_output_pin_o)
        else $error("host-wake pin did not rise when enabled");

    a_gpo_return: assert property ( // R14
        !st_reg.ctrl.host_wake |=> wake_output_pin_o == $past(shared_gpo_i))
        else $error("pin not returned to general output");

    a_timer_en: assert property ( // R17
        timer_cmp_i && st_reg.ctrl.timer_en |=> st_reg.stat.timer)
        else $error("timer compare did not set status");

    a_ack_once: assert property (
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
endmodule

// File: test/wake_pin_model.sv
/*
 Model of the external wake pins driven by the outside party.
 Assumes want_i is changed by the bench after a rising edge of clk_i.
*/
`timescale 1ns/1ps
module wake_pin_model #(
    parameter int HOLD = 40
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] want_i,
    output logic      [3:0] pins_o
);
    int cnt;

    // A new level is held long enough for two detector ticks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_o <= 4'h0;
            cnt    <= 0;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end else if (want_i != pins_o) begin
            pins_o <= want_i;
            cnt    <= HOLD;
        end
    end
endmodule

// File: test/sleep_wakeup_source_control_tb.sv
/*
 Self-checking bench for the wake-up source controller.
 Assumes a Wishbone slave answering in one cycle and a short divider.
*/
`timescale 1ns/1ps
module sleep_wakeup_source_control_tb;
    logic        clk_i, rst_i, cyc, stb, we, hib, doze, slow_tick;
    logic        tmr, cal, cirq, cdone, gpo, gpo_oe;
    logic        pin, pin_oe, wake_req_o, cpu_wake, conv_wake, irq;
    logic        ack_o;
    logic [3:0]  sel, want, pins;
    logic [31:0] adr, dat, dat_o, q;
    int          failures, tests_run;

    wake_pin_model pins_u (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
        .pins_o(pins));

    sleep_wakeup_source_control #(.DIV(16)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .sleep_hib_i(hib), .sleep_doze_i(doze), .slow_tick_i(slow_tick),
        .keypad_wake_input_i(pins), .timer_cmp_i(tmr), .cal_cmp_i(cal),
        .conv_irq_i(cirq), .conv_done_i(cdone), .shared_gpo_i(gpo),
        .shared_gpo_oe_i(gpo_oe), .wake_output_pin_o(pin),
        .wake_output_pin_oe_o(pin_oe), .wake_req_o(wake_req_o),
        .cpu_wake_o(cpu_wake), .conv_wake_o(conv_wake), .irq_o(irq));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Low-speed clock stand-in: one pulse every 4 cycles
    always @(posedge clk_i) slow_tick <= ($time / 20) % 4 == 0;

    task automatic close_out();
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [31:0] a, d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (ack_o !== 1'b1) begin
            failures++;
            close_out();
        end else begin
            cyc <= 1'b0;
            stb <= 1'b0;
            we  <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic wait_req();
        int n;
        n = 0;
        while (wake_req_o !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        if (wake_req_o !== 1'b1) begin
            failures++;
            close_out();
        end
    endtask

    task automatic pulse(input logic t, input logic c, input logic v);
        tmr  <= t;
        cal  <= c;
        cirq <= v;
        @(posedge clk_i);
        tmr  <= 1'b0;
        cal  <= 1'b0;
        cirq <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    initial begin
        failures = 0;
        tests_run = 0;
        {cyc, stb, we, hib, doze, tmr, cal, cirq, cdone} = '0;
        {gpo, adr, dat, sel, want} = '0;
        gpo_oe = 1'b1;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(wake_pkg::OFS_CTRL, 32'h0000_f000);
        rd(wake_pkg::OFS_STAT, 32'h0);
        rd(wake_pkg::OFS_MASK, 32'h0);
        rd(32'h0000_0010, 32'h0);
        chk({pin_oe, pin}, 2'b10);
        wr(wake_pkg::OFS_CTRL, 32'h0000_f004);
        repeat (2) @(posedge clk_i);
        chk({pin_oe, pin}, 2'b11);
        doze <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(pin, 1'b0);
        doze <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(pin, 1'b1);
        gpo <= 1'b1;
        gpo_oe <= 1'b0;
        wr(wake_pkg::OFS_CTRL, 32'h0000_f000);
        repeat (2) @(posedge clk_i);
        chk({pin_oe, pin}, 2'b01);
        wr(wake_pkg::OFS_MASK, 32'h0000_007f);
        pulse(1'b1, 1'b1, 1'b0);
        rd(wake_pkg::OFS_STAT, 32'h0);
        wr(wake_pkg::OFS_CTRL, 32'h0000_f003);
        pulse(1'b1, 1'b1, 1'b0);
        rd(wake_pkg::OFS_STAT, 32'h0000_0030);
        chk(irq, 1'b1);
        wr(wake_pkg::OFS_STAT, 32'h0000_0010);
        rd(wake_pkg::OFS_STAT, 32'h0000_0020);
        wr(wake_pkg::OFS_STAT, 32'h0000_0020);
        chk(irq, 1'b0);
        hib <= 1'b1;
        wr(wake_pkg::OFS_CTRL, 32'h0000_f00b);
        pulse(1'b1, 1'b0, 1'b0);
        chk({conv_wake, cpu_wake}, 2'b10);
        pulse(1'b0, 1'b0, 1'b1);
        chk(cpu_wake, 1'b1);
        wr(wake_pkg::OFS_CTRL, 32'h0000_f003);
        wr(wake_pkg::OFS_STAT, 32'h0000_007f);
        wr(wake_pkg::OFS_CTRL, 32'h0000_f010);
        want <= 4'b0001;
        wait_req();
        rd(wake_pkg::OFS_STAT, 32'h0000_0001);
        wr(wake_pkg::OFS_STAT, 32'h0000_0001);
        rd(wake_pkg::OFS_STAT, 32'h0000_0001);
        want <= 4'b0000;
        repeat (100) @(posedge clk_i);
        wr(wake_pkg::OFS_STAT, 32'h0000_0001);
        rd(wake_pkg::OFS_STAT, 32'h0);
        hib <= 1'b0;
        doze <= 1'b1;
        wr(wake_pkg::OFS_CTRL, 32'h0000_d220);
        want <= 4'b0010;
        repeat (100) @(posedge clk_i);
        rd(wake_pkg::OFS_STAT, 32'h0);
        want <= 4'b0100;
        wait_req();
        rd(wake_pkg::OFS_STAT, 32'h0000_0002);
        wr(wake_pkg::OFS_STAT, 32'h0000_0002);
        rd(wake_pkg::OFS_STAT, 32'h0);
        close_out();
    end
endmodule
